//--- verif/bcs_bus_partner.sv
`timescale 1ns/100ps
module bcs_bus_partner (
	// bus from the sequencer
	input  wire logic        CLK_I,
	input  wire logic [15:0] ADDR_I,
	input  wire logic        RD_N_I,
	input  wire logic        MEM_N_I,
	input  wire logic        PORT_N_I,
	// read data back
	output logic      [7:0]  DATA_O
);
	logic [7:0] last_ff = 8'h00;
	logic       sel;

	assign sel = !RD_N_I && !(MEM_N_I && PORT_N_I);

	always_ff @(posedge CLK_I) begin
		if (sel) begin
			last_ff <= DATA_O;
		end
	end

	// a released bus shows the inverse of the last byte, so stale data never matches
	always_comb begin
		if (sel) begin
			DATA_O = ADDR_I[7:0] ^ ADDR_I[15:8] ^ 8'hA5;
		end else begin
			DATA_O = ~last_ff;
		end
	end
endmodule : bcs_bus_partner

//--- verif/bcs_sequencer_properties.sv
`timescale 1ns/100ps
module bcs_sequencer_checker (
	// clock and reset
	input wire logic        CLK_I,
	input wire logic        RST_I,
	// watched ports
	input wire logic        START_I,
	input wire logic        BUSY_O,
	input wire logic        DONE_O,
	input wire logic [15:0] ADDR_O,
	input wire logic        DATA_OE_O,
	input wire logic        RD_N_O,
	input wire logic        WR_N_O,
	input wire logic        MEMORY_REQUEST_N_O,
	input wire logic        PORT_REQUEST_N_O,
	input wire logic        FETCH_CYCLE_N_O,
	input wire logic        OPCODE_BEGIN_N_O,
	input wire logic        HALT_N_O
);
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);

	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence taken_s;
		START_I && !BUSY_O;
	endsequence

	sequence first_fetch_s;
		(!FETCH_CYCLE_N_O && !OPCODE_BEGIN_N_O && !RD_N_O && !MEMORY_REQUEST_N_O) [*3];
	endsequence

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_start_then_fetch: assert property (taken_s |=> first_fetch_s)
		else $error("first fetch did not follow an accepted start");
	a_second_fetch_flag: assert property (first_fetch_s ##1 !FETCH_CYCLE_N_O |-> OPCODE_BEGIN_N_O [*3])
		else $error("begin flag low in second fetch");
	a_fetch_strobe_set: assert property (!FETCH_CYCLE_N_O |-> !RD_N_O && !MEMORY_REQUEST_N_O
		&& WR_N_O && PORT_REQUEST_N_O && HALT_N_O)
		else $error("fetch strobes wrong");
	a_port_read_set: assert property (!PORT_REQUEST_N_O |-> MEMORY_REQUEST_N_O && !RD_N_O
		&& WR_N_O && FETCH_CYCLE_N_O)
		else $error("port read strobes wrong");
	a_mem_write_set: assert property (!WR_N_O |-> !MEMORY_REQUEST_N_O && DATA_OE_O && RD_N_O
		&& PORT_REQUEST_N_O)
		else $error("memory write strobes wrong");
	a_idle_bus_quiet: assert property (MEMORY_REQUEST_N_O && PORT_REQUEST_N_O |-> RD_N_O
		&& WR_N_O && !DATA_OE_O)
		else $error("strobe or drive in idle state");
	a_write_three_states: assert property ($fell(WR_N_O) |=> (!WR_N_O && $stable(ADDR_O)) [*2])
		else $error("write cycle shorter than three states");
	a_strobe_only_busy: assert property (!(RD_N_O && WR_N_O) |-> BUSY_O)
		else $error("strobe outside an instruction");
	a_done_after_busy: assert property ($fell(BUSY_O) |-> DONE_O && RD_N_O && WR_N_O)
		else $error("no done pulse after last state");
endmodule : bcs_sequencer_checker

//--- verif/bcs_sequencer_tb_top.sv
`timescale 1ns/100ps
module bcs_sequencer_tb_top;
	import bcs_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        CLK_I = 1'b0, RST_I = 1'b1, START_I = 1'b0, COND_I = 1'b0, COUNT_NZ_I = 1'b0;
	bcs_class_t  CLASS_I = CL_IDX_STEP;
	logic [15:0] PC_I = 16'h0000, INDEX_I = 16'h0000, COUNT_PORT_I = 16'h0000;
	logic [15:0] POINTER_I = 16'h0000, ADDR_O, OPERAND_O, PC_O;
	logic [7:0]  ACC_I = 8'h00, WRITE_DATA_I = 8'h00, DATA_I, DATA_O, READ_DATA_O;
	logic        DATA_OE_O, RD_N_O, WR_N_O, MEMORY_REQUEST_N_O, PORT_REQUEST_N_O, HALT_N_O;
	logic        FETCH_CYCLE_N_O, OPCODE_BEGIN_N_O, BUSY_O, DONE_O, READ_VALID_O;
	logic [6:0]  sg;
	logic        prev_rd = 1'b0;
	logic [15:0] last_rd = 16'h0000;
	logic [31:0] obs[$], exp_q[$];
	integer      seed, num_errors = 0, tests_run = 0;
	// strobe sets {rd, wr, memory_request_n, port_request_n, fetch, halt, begin}
	localparam logic [6:0] F1 = 7'h2A, F2 = 7'h2B, RDM = 7'h2F, WRM = 7'h4F, IOR = 7'h37;
	localparam logic [6:0] IDL = 7'h7F;

	always #12.5 CLK_I = ~CLK_I;

	bcs_sequencer bcs_sequencer_inst (.CLK_I, .RST_I, .START_I, .CLASS_I, .COND_I, .COUNT_NZ_I,
		.PC_I, .INDEX_I, .COUNT_PORT_I, .POINTER_I, .ACC_I, .WRITE_DATA_I, .DATA_I, .ADDR_O,
		.DATA_O, .DATA_OE_O, .RD_N_O, .WR_N_O, .MEMORY_REQUEST_N_O, .PORT_REQUEST_N_O,
		.FETCH_CYCLE_N_O, .OPCODE_BEGIN_N_O, .HALT_N_O, .BUSY_O, .DONE_O, .READ_DATA_O,
		.READ_VALID_O, .OPERAND_O, .PC_O);

	bcs_bus_partner bcs_bus_partner_inst (.CLK_I, .ADDR_I(ADDR_O), .RD_N_I(RD_N_O),
		.MEM_N_I(MEMORY_REQUEST_N_O), .PORT_N_I(PORT_REQUEST_N_O), .DATA_O(DATA_I));

	// ------------------------------------------------------------
	// monitor: one entry per clock while busy, idle address ignored
	// ------------------------------------------------------------
	always @(negedge CLK_I) begin
		if (BUSY_O === 1'b1) begin
			sg = {RD_N_O, WR_N_O, MEMORY_REQUEST_N_O, PORT_REQUEST_N_O, FETCH_CYCLE_N_O,
				HALT_N_O, OPCODE_BEGIN_N_O};
			obs.push_back({READ_VALID_O, sg, DATA_OE_O ? DATA_O : 8'h00,
				sg == IDL ? 16'h0000 : ADDR_O});
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] dv(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction : dv

	// read-valid pulse shows in the first clock after each read cycle
	task automatic act(input logic [6:0] s, input logic [15:0] a, input logic [7:0] d);
		exp_q.push_back({prev_rd, s, d, a});
		repeat (2) exp_q.push_back({1'b0, s, d, a});
		prev_rd = (s != WRM);
		if (s != WRM)
			last_rd = a;
	endtask : act

	task automatic idl(input int n);
		for (int k = 0; k < n; k++)
			exp_q.push_back({(k == 0) ? prev_rd : 1'b0, IDL, 24'h000000});
		prev_rd = 1'b0;
	endtask : idl

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			num_errors++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	// one instruction, started at a falling edge; a second start mid-run must be ignored
	task automatic run(input bcs_class_t c, input logic cd, input logic nz);
		logic [15:0] p, ix, cp, pt, ea;
		logic [7:0]  ac, wd, d;
		int          n;
		p = 16'($random(seed));
		ix = 16'($random(seed));
		cp = 16'($random(seed));
		pt = 16'($random(seed));
		ac = 8'($random(seed));
		wd = 8'($random(seed));
		{CLASS_I, COND_I, COUNT_NZ_I, PC_I, INDEX_I} = {c, cd, nz, p, ix};
		{COUNT_PORT_I, POINTER_I, ACC_I, WRITE_DATA_I, START_I} = {cp, pt, ac, wd, 1'b1};
		obs = {};
		exp_q = {};
		prev_rd = 1'b0;
		d = dv(p + 16'h0002);
		ea = ix + {{8{d[7]}}, d};
		act(F1, p, 8'h00);
		n = 1;
		if (c inside {CL_IDX_STEP, CL_IDXREG_STEP, CL_IN_ZERO, CL_IN_REG, CL_IN_ONCE,
			CL_IN_REPEAT, CL_JP_IDX}) begin
			act(F2, p + 16'h0001, 8'h00);
			n++;
		end
		case (c)
			CL_IDX_STEP: begin
				act(RDM, p + 16'h0002, 8'h00);
				n++;
				idl(2);
				act(RDM, ea, 8'h00);
				idl(1);
				act(WRM, ea, wd);
			end
			CL_IDXREG_STEP, CL_PAIR_STEP: idl(1);
			CL_IN_DIRECT: begin
				act(RDM, p + 16'h0001, 8'h00);
				n++;
				act(IOR, {ac, dv(p + 16'h0001)}, 8'h00);
			end
			CL_IN_ZERO: begin
				act(RDM, p + 16'h0002, 8'h00);
				n++;
				act(IOR, {BCS_ZERO_PAGE, d}, 8'h00);
			end
			CL_IN_REG, CL_IN_ONCE, CL_IN_REPEAT: begin
				act(IOR, cp, 8'h00);
				if (c != CL_IN_REG)
					act(WRM, pt, dv(cp));
				if (c == CL_IN_REPEAT && nz)
					idl(2);
			end
			CL_JP_ABS, CL_JP_COND: begin
				act(RDM, p + 16'h0001, 8'h00);
				n++;
				if (c == CL_JP_ABS || cd) begin
					act(RDM, p + 16'h0002, 8'h00);
					n++;
				end
			end
			default: ;
		endcase
		@(negedge CLK_I);
		for (int k = 0; k < 40 && DONE_O !== 1'b1; k++) begin
			START_I = (k == 0);
			CLASS_I = bcs_class_t'(4'($unsigned($random(seed)) % 12));
			@(negedge CLK_I);
			START_I = 1'b0;
		end
		check({31'h0, DONE_O}, 32'h1);
		check(obs.size(), exp_q.size());
		// cycle order and strobes
		foreach (exp_q[i])
			check(i < obs.size() ? obs[i] : 32'h0, exp_q[i]);
		// operand bytes, low first
		if (c == CL_JP_ABS || (c == CL_JP_COND && cd))
			check({16'h0, OPERAND_O}, {16'h0, d, dv(p + 16'h0001)});
		check({16'h0, PC_O}, {16'h0, p + 16'(n)});
		check({24'h0, READ_DATA_O}, {24'h0, dv(last_rd)});
	endtask : run

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		seed = 93295;
		repeat (10) @(negedge CLK_I);
		RST_I = 1'b0;
		for (int i = 0; i < 24; i++)
			run(bcs_class_t'(4'(i % 12)), i >= 12, i < 12);
		repeat (40)
			run(bcs_class_t'(4'($unsigned($random(seed)) % 12)), 1'($random(seed)),
				1'($random(seed)));
		report_and_stop();
	end

	initial begin
		#(25 * 4000);
		num_errors++;
		report_and_stop();
	end
endmodule : bcs_sequencer_tb_top

bind bcs_sequencer bcs_sequencer_checker bcs_sequencer_checker_inst (.CLK_I, .RST_I, .START_I,
	.BUSY_O, .DONE_O, .ADDR_O, .DATA_OE_O, .RD_N_O, .WR_N_O, .MEMORY_REQUEST_N_O,
	.PORT_REQUEST_N_O, .FETCH_CYCLE_N_O, .OPCODE_BEGIN_N_O, .HALT_N_O);

//--- verilog/bcs_pkg.sv
package bcs_pkg;

	// ------------------------------------------------------------
	// instruction groups sequenced by this block
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CL_IDX_STEP,      // increment/decrement at index plus displacement
		CL_IDXREG_STEP,   // increment/decrement of an index register
		CL_PAIR_STEP,     // increment/decrement of a 16-bit pair
		CL_IN_DIRECT,     // port input to accumulator, immediate port
		CL_IN_ZERO,       // port_in_zero_page
		CL_IN_REG,        // port input through the count/port pair
		CL_IN_ONCE,       // port_in_up_once / port_in_down_once
		CL_IN_REPEAT,     // block_port_in_up_repeat / block_port_in_down_repeat
		CL_JP_ABS,        // jump_absolute
		CL_JP_COND,       // conditional jump_absolute
		CL_JP_HL,         // register-indirect jump, one opcode byte
		CL_JP_IDX         // index-register jump, two opcode bytes
	} bcs_class_t;

	// ------------------------------------------------------------
	// machine cycle kinds
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CK_FETCH1,
		CK_FETCH2,
		CK_OPRD,
		CK_MEMRD,
		CK_MEMWR,
		CK_IORD,
		CK_IDLE,
		CK_END
	} bcs_kind_t;

	typedef enum logic {
		ST_WAIT,
		ST_RUN
	} bcs_state_t;

	// ------------------------------------------------------------
	// widths, t-state codes and reset values
	// ------------------------------------------------------------
	localparam int          BCS_STEP_W    = 4;
	localparam logic [1:0]  BCS_T1        = 2'h0;
	localparam logic [1:0]  BCS_T3        = 2'h2;
	localparam logic [1:0]  BCS_T_INC     = 2'h1;
	localparam logic [3:0]  BCS_STEP_INC  = 4'h1;
	localparam logic [15:0] BCS_PC_INC    = 16'h0001;
	localparam logic [7:0]  BCS_ZERO_PAGE = 8'h00;
	localparam logic [15:0] BCS_ADDR_RST  = 16'h0000;
	localparam logic [7:0]  BCS_BYTE_RST  = 8'h00;

endpackage : bcs_pkg

//--- verilog/bcs_sequencer.sv
// Notes on behaviour
// - indexed step: fetch, fetch, displacement, idle, idle, read, idle, write.
// - index register step: two fetches then one idle, no further access.
// - direct port input: port read, immediate byte low, accumulator high.
// - zero-page input: two fetches, port byte, port read with high byte zero.
// - register-indirect input: two fetches then port read at the count/port pair.
// - block input: port read, memory write, two idles only while count nonzero.
// - conditional jump reads low then high byte; false condition stops after one.
// - fetch drives read, memory request, fetch low; begin flag low first fetch only.
// - port read uses port request; write uses memory request; idle holds strobes high.
`timescale 1ns/100ps
module bcs_sequencer
	import bcs_pkg::*;
(
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// instruction request
	input  wire logic        START_I,
	input  bcs_class_t       CLASS_I,
	input  wire logic        COND_I,
	input  wire logic        COUNT_NZ_I,
	input  wire logic [15:0] PC_I,
	input  wire logic [15:0] INDEX_I,
	input  wire logic [15:0] COUNT_PORT_I,
	input  wire logic [15:0] POINTER_I,
	input  wire logic [7:0]  ACC_I,
	input  wire logic [7:0]  WRITE_DATA_I,
	// bus
	input  wire logic [7:0]  DATA_I,
	output logic      [15:0] ADDR_O,
	output logic      [7:0]  DATA_O,
	output logic             DATA_OE_O,
	output logic             RD_N_O,
	output logic             WR_N_O,
	output logic             MEMORY_REQUEST_N_O,
	output logic             PORT_REQUEST_N_O,
	output logic             FETCH_CYCLE_N_O,
	output logic             OPCODE_BEGIN_N_O,
	output logic             HALT_N_O,
	// status
	output logic             BUSY_O,
	output logic             DONE_O,
	output logic      [7:0]  READ_DATA_O,
	output logic             READ_VALID_O,
	output logic      [15:0] OPERAND_O,
	output logic      [15:0] PC_O
);

	// ------------------------------------------------------------
	// cycle table
	// ------------------------------------------------------------
	function automatic bcs_kind_t kind_of(input bcs_class_t cls, input logic [3:0] stp,
	                                      input logic cnd, input logic cnz);
		bcs_kind_t k;
		k = CK_END;
		unique case (cls)
			CL_IDX_STEP: case (stp)
				4'h0: k = CK_FETCH1;
				4'h1: k = CK_FETCH2;
				4'h2: k = CK_OPRD;
				4'h3, 4'h4, 4'h6: k = CK_IDLE;
				4'h5: k = CK_MEMRD;
				4'h7: k = CK_MEMWR;
				default: k = CK_END;
			endcase
			CL_IDXREG_STEP: case (stp)
				4'h0: k = CK_FETCH1;
				4'h1: k = CK_FETCH2;
				4'h2: k = CK_IDLE;
				default: k = CK_END;
			endcase
			CL_PAIR_STEP: case (stp)
				4'h0: k = CK_FETCH1;
				4'h1: k = CK_IDLE;
				default: k = CK_END;
			endcase
			// third cycle is the port read
			CL_IN_DIRECT: case (stp)
				4'h0: k = CK_FETCH1;
				4'h1: k = CK_OPRD;
				4'h2: k = CK_IORD;
				default: k = CK_END;
			endcase
			// fetch, fetch, port byte, port read
			CL_IN_ZERO: case (stp)
				4'h0: k = CK_FETCH1;
				4'h1: k = CK_FETCH2;
				4'h2: k = CK_OPRD;
				4'h3: k = CK_IORD;
				default: k = CK_END;
			endcase
			CL_IN_REG: case (stp)
				4'h0: k = CK_FETCH1;
				4'h1: k = CK_FETCH2;
				4'h2: k = CK_IORD;
				default: k = CK_END;
			endcase
			CL_IN_ONCE, CL_IN_REPEAT: case (stp)
				4'h0: k = CK_FETCH1;
				4'h1: k = CK_FETCH2;
				4'h2: k = CK_IORD;
				4'h3: k = CK_MEMWR;
				// trailing idles only while count nonzero
				4'h4, 4'h5: k = (cls == CL_IN_REPEAT && cnz) ? CK_IDLE : CK_END;
				default: k = CK_END;
			endcase
			CL_JP_ABS, CL_JP_COND: case (stp)
				4'h0: k = CK_FETCH1;
				4'h1: k = CK_OPRD;
				// second operand always for jump_absolute, for the conditional jump only when condition holds
				4'h2: k = (cls == CL_JP_ABS || cnd) ? CK_OPRD : CK_END;
				default: k = CK_END;
			endcase
			CL_JP_HL: k = (stp == 4'h0) ? CK_FETCH1 : CK_END;
			CL_JP_IDX: case (stp)
				4'h0: k = CK_FETCH1;
				4'h1: k = CK_FETCH2;
				default: k = CK_END;
			endcase
		endcase
		return k;
	endfunction : kind_of

	// ------------------------------------------------------------
	// sequencing state
	// ------------------------------------------------------------
	bcs_state_t             state_ff,  nxt_state;
	bcs_class_t             class_ff,  cls;
	logic                   cond_ff,   cnd;
	logic                   cnz_ff,    cnz;
	logic [BCS_STEP_W-1:0]  step_ff,   nxt_step;
	logic [1:0]             tst_ff,    nxt_tst;
	logic [15:0]            pc_ff,     nxt_pc;
	logic [7:0]             lo_ff,     nxt_lo;
	logic [7:0]             hi_ff,     nxt_hi;
	logic [7:0]             port_ff,   nxt_port;
	logic [15:0]            index_ff;
	logic [15:0]            cntp_ff;
	logic [15:0]            ptr_ff;
	logic [7:0]             acc_ff;
	bcs_kind_t              kind_cur,  nxt_kind;
	logic                   cyc_end;
	logic                   rd_done;

	assign kind_cur = kind_of(class_ff, step_ff, cond_ff, cnz_ff);
	// idle states last one clock, active cycles T1..T3
	assign cyc_end  = (kind_cur == CK_IDLE) || (tst_ff == BCS_T3);
	assign rd_done  = (state_ff == ST_RUN) && cyc_end && (kind_cur inside
	                  {CK_FETCH1, CK_FETCH2, CK_OPRD, CK_MEMRD, CK_IORD});

	always_comb begin
		nxt_state = state_ff;
		nxt_step  = step_ff;
		nxt_tst   = tst_ff;
		nxt_pc    = pc_ff;
		nxt_lo    = lo_ff;
		nxt_hi    = hi_ff;
		nxt_port  = port_ff;
		cls       = class_ff;
		cnd       = cond_ff;
		cnz       = cnz_ff;
		if (state_ff == ST_WAIT) begin
			if (START_I) begin
				nxt_state = ST_RUN;
				nxt_step  = '0;
				nxt_tst   = BCS_T1;
				nxt_pc    = PC_I;
				nxt_lo    = BCS_BYTE_RST;
				nxt_hi    = BCS_BYTE_RST;
				cls       = CLASS_I;
				cnd       = COND_I;
				cnz       = COUNT_NZ_I;
			end
		end else if (cyc_end) begin
			if (kind_cur inside {CK_FETCH1, CK_FETCH2, CK_OPRD})
				nxt_pc = pc_ff + BCS_PC_INC;
			// low byte arrives first, shifts down on the second
			if (kind_cur == CK_OPRD) begin
				nxt_hi = DATA_I;
				nxt_lo = hi_ff;
			end
			if (kind_cur == CK_IORD)
				nxt_port = DATA_I;
			nxt_step = step_ff + BCS_STEP_INC;
			nxt_tst  = BCS_T1;
			if (kind_of(class_ff, nxt_step, cond_ff, cnz_ff) == CK_END)
				nxt_state = ST_WAIT;
		end else begin
			nxt_tst = tst_ff + BCS_T_INC;
		end
		nxt_kind = (nxt_state == ST_RUN) ? kind_of(cls, nxt_step, cnd, cnz) : CK_END;
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state_ff <= ST_WAIT;
			class_ff <= CL_JP_HL;
			cond_ff  <= 1'b0;
			cnz_ff   <= 1'b0;
			step_ff  <= '0;
			tst_ff   <= BCS_T1;
			pc_ff    <= BCS_ADDR_RST;
			lo_ff    <= BCS_BYTE_RST;
			hi_ff    <= BCS_BYTE_RST;
			port_ff  <= BCS_BYTE_RST;
		end else begin
			state_ff <= nxt_state;
			class_ff <= cls;
			cond_ff  <= cnd;
			cnz_ff   <= cnz;
			step_ff  <= nxt_step;
			tst_ff   <= nxt_tst;
			pc_ff    <= nxt_pc;
			lo_ff    <= nxt_lo;
			hi_ff    <= nxt_hi;
			port_ff  <= nxt_port;
		end
	end

	// register operands are frozen for the whole instruction
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			index_ff <= BCS_ADDR_RST;
			cntp_ff  <= BCS_ADDR_RST;
			ptr_ff   <= BCS_ADDR_RST;
			acc_ff   <= BCS_BYTE_RST;
		end else if (state_ff == ST_WAIT && START_I) begin
			index_ff <= INDEX_I;
			cntp_ff  <= COUNT_PORT_I;
			ptr_ff   <= POINTER_I;
			acc_ff   <= ACC_I;
		end
	end

	// ------------------------------------------------------------
	// bus drive, registered from the upcoming cycle
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ADDR_O <= BCS_ADDR_RST;
		end else begin
			unique case (nxt_kind)
				CK_FETCH1, CK_FETCH2, CK_OPRD: ADDR_O <= nxt_pc;
				CK_MEMRD, CK_MEMWR: ADDR_O <= (cls == CL_IDX_STEP)
					? index_ff + {{8{nxt_hi[7]}}, nxt_hi} : ptr_ff;
				CK_IORD: begin
					if (cls == CL_IN_DIRECT)
						ADDR_O <= {acc_ff, nxt_hi};
					// zero page on the upper lines
					else if (cls == CL_IN_ZERO)
						ADDR_O <= {BCS_ZERO_PAGE, nxt_hi};
					else
						ADDR_O <= cntp_ff;
				end
				CK_IDLE, CK_END: ADDR_O <= ADDR_O;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			RD_N_O             <= 1'b1;
			WR_N_O             <= 1'b1;
			MEMORY_REQUEST_N_O <= 1'b1;
			PORT_REQUEST_N_O   <= 1'b1;
			FETCH_CYCLE_N_O    <= 1'b1;
			OPCODE_BEGIN_N_O   <= 1'b1;
			HALT_N_O           <= 1'b1;
			DATA_OE_O          <= 1'b0;
			DATA_O             <= BCS_BYTE_RST;
		end else begin
			// fetch strobes, begin flag on first fetch only
			RD_N_O             <= !(nxt_kind inside
			                        {CK_FETCH1, CK_FETCH2, CK_OPRD, CK_MEMRD, CK_IORD});
			// write with memory request, port read with port request
			WR_N_O             <= (nxt_kind != CK_MEMWR);
			MEMORY_REQUEST_N_O <= !(nxt_kind inside
			                        {CK_FETCH1, CK_FETCH2, CK_OPRD, CK_MEMRD, CK_MEMWR});
			PORT_REQUEST_N_O   <= (nxt_kind != CK_IORD);
			FETCH_CYCLE_N_O    <= !(nxt_kind inside {CK_FETCH1, CK_FETCH2});
			OPCODE_BEGIN_N_O   <= (nxt_kind != CK_FETCH1);
			HALT_N_O           <= 1'b1;
			// data floats except during a write
			DATA_OE_O          <= (nxt_kind == CK_MEMWR);
			if (nxt_kind == CK_MEMWR)
				DATA_O <= (cls == CL_IDX_STEP) ? WRITE_DATA_I : nxt_port;
		end
	end

	// ------------------------------------------------------------
	// status
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			BUSY_O       <= 1'b0;
			DONE_O       <= 1'b0;
			READ_DATA_O  <= BCS_BYTE_RST;
			READ_VALID_O <= 1'b0;
			OPERAND_O    <= BCS_ADDR_RST;
			PC_O         <= BCS_ADDR_RST;
		end else begin
			BUSY_O       <= (nxt_state == ST_RUN);
			DONE_O       <= (state_ff == ST_RUN) && (nxt_state == ST_WAIT);
			READ_VALID_O <= rd_done;
			if (rd_done)
				READ_DATA_O <= DATA_I;
			OPERAND_O    <= {nxt_hi, nxt_lo};
			PC_O         <= nxt_pc;
		end
	end

endmodule : bcs_sequencer
